//--- bench/switch_bank.sv
// Far-side switch bank: turns a requested code into one sample pulse.
// Assumes the bench asks at most once per pulse.
`timescale 1ns/1ps
module switch_bank (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [4:0] pin,
    input  wire logic [9:0] code,
    output logic            sample_valid,
    output logic      [4:0] sample_input,
    output logic      [9:0] sample_code
);
    // The released code line shows junk so a stale code never looks valid
    always_ff @(posedge clock) begin
        sample_valid <= go;
        sample_input <= pin;
        sample_code  <= go ? code : ~sample_code;
    end
endmodule : switch_bank

//--- bench/switch_input_config_checker.sv
// Port checker for the switch input block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module switch_input_config_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        sample_valid,
    input wire logic        poll_cycle_end,
    input wire logic [23:0] source_enable,
    input wire logic [9:0]  sink_enable,
    input wire logic [71:0] wetting_code,
    input wire logic [23:0] adc_path_select,
    input wire logic        running,
    input wire logic        cleaning_active,
    input wire logic        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($fell(rst) |-> adc_path_select == 0 && source_enable == 0 && !irq)
        else $error("outputs not clear after reset");
    src_sink_apart_a: assert property ((source_enable[9:0] & sink_enable) == 0)
        else $error("source and sink on together");
    stopped_off_a: assert property (!running && !$past(running) |-> source_enable == 0 && sink_enable == 0)
        else $error("current on while stopped");
    clean_level_a: assert property ($rose(cleaning_active) |-> wetting_code == {24{3'h4}})
        else $error("cleaning pulse at wrong current");
    clean_cause_a: assert property ($rose(cleaning_active) |-> $past(poll_cycle_end, 2) && running)
        else $error("cleaning pulse without poll end");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 0)
        else $error("read data outside read answer");
    irq_drop_a: assert property ($fell(irq) |-> $past(reg_read) || $past(reg_write, 2))
        else $error("interrupt dropped without access");
    irq_raise_a: assert property ($rose(irq) |-> $past(sample_valid) || $past(reg_write, 2))
        else $error("interrupt raised without cause");
    cover property ($rose(cleaning_active));
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule : switch_input_config_checker
bind switch_input_config switch_input_config_checker chk_i (.clock, .rst, .reg_write, .reg_read, .reg_rdata,
    .sample_valid, .poll_cycle_end, .source_enable, .sink_enable, .wetting_code, .adc_path_select, .running,
    .cleaning_active, .irq);

//--- bench/tb.sv
// Bench for the switch input block: register tasks and sample pulses.
// Assumes the design, its bound checker and the switch bank model.
`timescale 1ns/1ps
`include "switch_input_cfg.svh"
module tb;
    logic        clock, rst, reg_write, reg_read, go, poll_cycle_end, sample_valid, running, cleaning_active, irq;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [4:0]  pin, sample_input;
    logic [9:0]  code, sample_code, sink_enable;
    logic [23:0] source_enable, adc_path_select;
    logic [71:0] wetting_code;
    int          fail_count = 0, total_checks = 0, cycles = 0;
    int          lvl[4] = '{341, 460, 511, 682};
    logic [37:0] cfg[15] = '{{6'h01, 32'h1}, {6'h02, 32'h801001}, {6'h03, 32'h801409}, {6'h05, 32'h12492},
        {6'h07, 32'hC8}, {6'h0B, 32'h64}, {6'h10, 32'h3}, {6'h12, 32'h12C}, {6'h13, 32'h190}, {6'h14, 32'hA},
        {6'h15, 32'h14}, {6'h16, 32'h1E}, {6'h17, 32'h28}, {6'h18, 32'h32}, {6'h1F, 32'h8}};
    switch_input_config dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sample_valid,
        .sample_input, .sample_code, .poll_cycle_end, .source_enable, .sink_enable, .wetting_code,
        .adc_path_select, .running, .cleaning_active, .irq);
    switch_bank sb (.clock, .go, .pin, .code, .sample_valid, .sample_input, .sample_code);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            finish_test;
        end
    end
    task chk(input string n, input logic [71:0] s, input logic [71:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr
    task rd(input logic [5:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata, e);
        @(posedge clock);
    endtask : rd
    task smp(input logic [4:0] p, input logic [9:0] c);
        go <= 1'b1;
        pin <= p;
        code <= c;
        @(posedge clock);
        go <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : smp
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        {rst, reg_write, reg_read, go, poll_cycle_end} = 5'h10;
        {reg_addr, reg_wdata, pin, code} = 53'h0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int a = 0; a < 8; a++) rd(6'(a), 32'h0);
        wr(6'h3F, 32'hFFFFFFFF);
        rd(6'h3F, 32'h0);
        foreach (cfg[i]) wr(cfg[i][37:32], cfg[i][31:0]);
        rd(6'h0B, 32'h64);
        wr(6'h00, 32'h1);
        repeat (2) @(posedge clock);
        chk("sink", sink_enable, 10'h001);
        chk("source", source_enable, 24'h801408);
        chk("adcpath", adc_path_select, 24'h801001);
        chk("running", running, 1'b1);
        chk("wetting", wetting_code, 72'h492492492);
        wr(6'h01, 32'h3FF);
        rd(6'h01, 32'h1);
        smp(5'h00, 10'h096);
        smp(5'h0C, 10'h14A);
        smp(5'h17, 10'h023);
        rd(6'h1A, 32'h01000001);
        rd(6'h1B, 32'h00380000);
        for (int i = 0; i < 4; i++) begin
            wr(6'h00, 32'h0);
            wr(6'h04, 32'(i));
            wr(6'h00, 32'h1);
            smp(5'h03, 10'(lvl[i]));
            rd(6'h19, 32'h0);
            smp(5'h03, 10'(lvl[i] + 1));
            rd(6'h19, 32'h8);
            chk("irq", irq, 1'b1);
            rd(6'h1C, 32'h8);
            chk("irq", irq, 1'b0);
        end
        smp(5'h05, 10'h3FF);
        rd(6'h19, 32'h8);
        wr(6'h00, 32'h3);
        poll_cycle_end <= 1'b1;
        @(posedge clock);
        poll_cycle_end <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("clean", cleaning_active, 1'b1);
        chk("wetclean", wetting_code, {24{`WET_CLEAN_CODE}});
        repeat (`TICK_CYCLES * `CLEAN_PULSE_US + 4) @(posedge clock);
        chk("cleanend", cleaning_active, 1'b0);
        chk("wetback", wetting_code, 72'h492492492);
        // One-threshold watch: low level copied from high, only high unmasked
        wr(6'h00, 32'h0);
        wr(6'h12, 32'h190);
        wr(6'h20, 32'h02000000);
        wr(6'h00, 32'h1);
        smp(5'h0C, 10'h191);
        chk("irqadc", irq, 1'b1);
        rd(6'h1D, 32'h03000001);
        chk("irqadcclr", irq, 1'b0);
        finish_test;
    end
endmodule : tb

//--- src/level_judge.sv
// Judges one ADC sample against the threshold levels of its input.
// Assumes sample and settings are stable in the clock domain of the caller.
`timescale 1ns/1ps
module level_judge
    import switch_input_types::*;
(
    input  wire logic [4:0]  input_index,
    input  wire logic [9:0]  code,
    input  wire logic [79:0] slot_levels,
    input  wire logic [35:0] slot_assign,
    input  wire level_t      shared_level,
    input  wire level_t      pair_low,
    input  wire level_t      pair_high,
    input  wire level_t      triple_low,
    input  wire level_t      triple_mid,
    input  wire level_t      triple_high,
    input  wire level_t      last_level4,
    input  wire level_t      last_level5,
    output logic [4:0]       above
);
    always_comb begin
        int     base;
        logic [2:0] sel;
        base  = 3 * int'(input_index);
        sel   = 3'h0;
        above = 5'h00;
        if (input_index < 5'h0C) begin
            sel      = slot_assign[base +: 3];
            above[0] = code > slot_levels[int'(sel) * 10 +: 10];
            above[1] = code > shared_level;
        end else if (input_index < 5'h12) begin
            above[0] = code > pair_low;
            above[1] = code > pair_high;
        end else begin
            above[0] = code > triple_low;
            above[1] = code > triple_mid;
            above[2] = code > triple_high;
            if (input_index == 5'h17) begin
                above[3] = code > last_level4;
                above[4] = code > last_level5;
            end
        end
    end
endmodule : level_judge

//--- src/switch_input_cfg.svh
// Constants for the switch input configuration block: register offsets,
// field positions, reset values and timing counts.
// Assumes the register port uses a 6-bit word address.
`ifndef SWITCH_INPUT_CFG_SVH
`define SWITCH_INPUT_CFG_SVH

`define REG_RUN          6'h00
`define REG_CS_SELECT    6'h01
`define REG_MODE         6'h02
`define REG_IN_EN        6'h03
`define REG_COMP_LEVEL   6'h04
`define REG_WET_A        6'h05
`define REG_WET_B        6'h06
`define REG_SHARED       6'h07
`define REG_SLOT_PAGE    3'h1
`define REG_ASSIGN_A     6'h10
`define REG_ASSIGN_B     6'h11
`define REG_PAIR_LOW     6'h12
`define REG_PAIR_HIGH    6'h13
`define REG_TRIPLE_LOW   6'h14
`define REG_TRIPLE_MID   6'h15
`define REG_TRIPLE_HIGH  6'h16
`define REG_LAST_LEVEL4  6'h17
`define REG_LAST_LEVEL5  6'h18
`define REG_COMP_STATE   6'h19
`define REG_ADC_STATE_LO 6'h1A
`define REG_ADC_STATE_HI 6'h1B
`define REG_IRQ_COMP     6'h1C
`define REG_IRQ_ADC_LO   6'h1D
`define REG_IRQ_ADC_HI   6'h1E
`define REG_MASK_COMP    6'h1F
`define REG_ADC_MASK_1   6'h20
`define REG_ADC_MASK_2   6'h21

`define RUN_BIT          0
`define CCP_BIT          1

`define RST_CS_SELECT    10'h000
`define RST_MODE         24'h000000
`define RST_IN_EN        24'h000000
`define RST_COMP_LEVEL   12'h000
`define RST_WET          18'h00000
`define RST_LEVEL        10'h000
`define RST_ASSIGN_A     30'h00000000
`define RST_ASSIGN_B     6'h00
`define RST_MASK_COMP    24'h000000
`define RST_MASK_ADC     56'h00000000000000

`define WET_CLEAN_CODE   3'h4
`define ADC_MAX_CODE     1023
`define ADC_FULL_MV      6000
`define COMP_LEVEL0_MV   2000
`define COMP_LEVEL1_MV   2700
`define COMP_LEVEL2_MV   3000
`define COMP_LEVEL3_MV   4000

`define CLOCK_MHZ        25
`define TICK_CYCLES      (`CLOCK_MHZ)
`define CLEAN_PULSE_US   20

`endif

//--- src/switch_input_config.sv
// Configuration and detection front end for 24 switch inputs.
// Assumes samples and the poll-end pulse come from logic on the same clock.
`timescale 1ns/1ps
`include "switch_input_cfg.svh"

// What this block does
// - Inputs 10 to 23 always use a current source and never a sink.
// - One select bit per input 0 to 9 picks the sink when 1, the source after reset.
// - Each input has a mode bit choosing comparator or ADC judgement.
// - Reset puts every input into comparator mode.
// - A disabled input has source and sink off and is not monitored.
// - Reset clears every input enable bit.
// - Each group of four inputs picks one of four comparator levels, 2, 2.7, 3 or 4 V.
// - Inputs 0 to 11 in ADC mode each use one of eight 10-bit programmable levels.
// - A shared level applies to inputs 0 to 11 beside each one's own level.
// - Inputs 12-17 use two levels, 18-22 three, and input 23 five.
// - Wetting current is one of 0, 1, 2, 5, 10 or 15 mA over two registers, 0 mA after reset.
// - The ADC maps 0 V to 6 V onto its full 10-bit code range.
// - With cleaning polling on, a short high-current pulse ends every polling cycle.
module switch_input_config
    import switch_input_types::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        sample_valid,
    input  wire logic [4:0]  sample_input,
    input  wire logic [9:0]  sample_code,
    input  wire logic        poll_cycle_end,
    output logic      [23:0] source_enable,
    output logic      [9:0]  sink_enable,
    output logic      [71:0] wetting_code,
    output logic      [23:0] adc_path_select,
    output logic             running,
    output logic             cleaning_active,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic         run, next_run;
    logic         ccp_en, next_ccp_en;
    logic [9:0]   cs_select, next_cs_select;
    logic [23:0]  mode, next_mode;
    logic [23:0]  in_en, next_in_en;
    logic [11:0]  comp_level, next_comp_level;
    logic [35:0]  wet_cfg, next_wet_cfg;
    level_t       shared_level, next_shared_level;
    logic [79:0]  slots, next_slots;
    logic [35:0]  slot_assign, next_slot_assign;
    level_t       pair_low, next_pair_low;
    level_t       pair_high, next_pair_high;
    level_t       triple_low, next_triple_low;
    level_t       triple_mid, next_triple_mid;
    level_t       triple_high, next_triple_high;
    level_t       last_level4, next_last_level4;
    level_t       last_level5, next_last_level5;
    logic [23:0]  mask_comp, next_mask_comp;
    logic [55:0]  mask_adc, next_mask_adc;

    always_comb begin
        next_run          = run;
        next_ccp_en       = ccp_en;
        next_cs_select    = cs_select;
        next_mode         = mode;
        next_in_en        = in_en;
        next_comp_level   = comp_level;
        next_wet_cfg      = wet_cfg;
        next_shared_level = shared_level;
        next_slots        = slots;
        next_slot_assign  = slot_assign;
        next_pair_low     = pair_low;
        next_pair_high    = pair_high;
        next_triple_low   = triple_low;
        next_triple_mid   = triple_mid;
        next_triple_high  = triple_high;
        next_last_level4  = last_level4;
        next_last_level5  = last_level5;
        next_mask_comp    = mask_comp;
        next_mask_adc     = mask_adc;
        if (reg_write) begin
            case (reg_addr)
                `REG_RUN: begin
                    next_run    = reg_wdata[`RUN_BIT];
                    next_ccp_en = reg_wdata[`CCP_BIT];
                end
                `REG_MASK_COMP:  next_mask_comp       = reg_wdata[23:0];
                `REG_ADC_MASK_1: next_mask_adc[31:0]  = reg_wdata;
                `REG_ADC_MASK_2: next_mask_adc[55:32] = reg_wdata[23:0];
                default: ;
            endcase
            // Settings are frozen while running so sampling never sees a half change
            if (!run) begin
                if (reg_addr[5:3] == `REG_SLOT_PAGE) begin
                    next_slots[int'(reg_addr[2:0]) * 10 +: 10] = reg_wdata[9:0];
                end
                case (reg_addr)
                    `REG_CS_SELECT:   next_cs_select        = reg_wdata[9:0];
                    `REG_MODE:        next_mode             = reg_wdata[23:0];
                    `REG_IN_EN:       next_in_en            = reg_wdata[23:0];
                    `REG_COMP_LEVEL:  next_comp_level       = reg_wdata[11:0];
                    `REG_WET_A:       next_wet_cfg[17:0]    = reg_wdata[17:0];
                    `REG_WET_B:       next_wet_cfg[35:18]   = reg_wdata[17:0];
                    `REG_SHARED:      next_shared_level     = reg_wdata[9:0];
                    `REG_ASSIGN_A:    next_slot_assign[29:0]  = reg_wdata[29:0];
                    `REG_ASSIGN_B:    next_slot_assign[35:30] = reg_wdata[5:0];
                    `REG_PAIR_LOW:    next_pair_low         = reg_wdata[9:0];
                    `REG_PAIR_HIGH:   next_pair_high        = reg_wdata[9:0];
                    `REG_TRIPLE_LOW:  next_triple_low       = reg_wdata[9:0];
                    `REG_TRIPLE_MID:  next_triple_mid       = reg_wdata[9:0];
                    `REG_TRIPLE_HIGH: next_triple_high      = reg_wdata[9:0];
                    `REG_LAST_LEVEL4: next_last_level4      = reg_wdata[9:0];
                    `REG_LAST_LEVEL5: next_last_level5      = reg_wdata[9:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            run          <= 1'b0;
            ccp_en       <= 1'b0;
            cs_select    <= `RST_CS_SELECT;
            mode         <= `RST_MODE;
            in_en        <= `RST_IN_EN;
            comp_level   <= `RST_COMP_LEVEL;
            wet_cfg      <= {2{`RST_WET}};
            shared_level <= `RST_LEVEL;
            slots        <= {8{`RST_LEVEL}};
            slot_assign  <= {`RST_ASSIGN_B, `RST_ASSIGN_A};
            pair_low     <= `RST_LEVEL;
            pair_high    <= `RST_LEVEL;
            triple_low   <= `RST_LEVEL;
            triple_mid   <= `RST_LEVEL;
            triple_high  <= `RST_LEVEL;
            last_level4  <= `RST_LEVEL;
            last_level5  <= `RST_LEVEL;
            mask_comp    <= `RST_MASK_COMP;
            mask_adc     <= `RST_MASK_ADC;
        end else begin
            run          <= next_run;
            ccp_en       <= next_ccp_en;
            cs_select    <= next_cs_select;
            mode         <= next_mode;
            in_en        <= next_in_en;
            comp_level   <= next_comp_level;
            wet_cfg      <= next_wet_cfg;
            shared_level <= next_shared_level;
            slots        <= next_slots;
            slot_assign  <= next_slot_assign;
            pair_low     <= next_pair_low;
            pair_high    <= next_pair_high;
            triple_low   <= next_triple_low;
            triple_mid   <= next_triple_mid;
            triple_high  <= next_triple_high;
            last_level4  <= next_last_level4;
            last_level5  <= next_last_level5;
            mask_comp    <= next_mask_comp;
            mask_adc     <= next_mask_adc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample judgement and status

    // Comparator level as an ADC code over the 0 V to 6 V span
    function automatic level_t comp_code(input logic [1:0] sel);
        int mv;
        case (sel)
            2'h0:    mv = `COMP_LEVEL0_MV;
            2'h1:    mv = `COMP_LEVEL1_MV;
            2'h2:    mv = `COMP_LEVEL2_MV;
            default: mv = `COMP_LEVEL3_MV;
        endcase
        return level_t'(mv * `ADC_MAX_CODE / `ADC_FULL_MV);
    endfunction : comp_code

    function automatic int input_of(input int b);
        if (b < 24) return b / 2;
        if (b < 36) return 12 + (b - 24) / 2;
        if (b < 51) return 18 + (b - 36) / 3;
        return 23;
    endfunction : input_of

    function automatic int level_of(input int b);
        if (b < 24) return b % 2;
        if (b < 36) return (b - 24) % 2;
        if (b < 51) return (b - 36) % 3;
        return b - 51;
    endfunction : level_of

    logic [4:0]  above;
    logic [23:0] hit;
    logic [23:0] comp_state, next_comp_state, comp_evt;
    logic [55:0] adc_state, next_adc_state, adc_evt;
    logic [23:0] irq_comp, next_irq_comp;
    logic [55:0] irq_adc, next_irq_adc;

    level_judge judge (
        .input_index  (sample_input),
        .code         (sample_code),
        .slot_levels  (slots),
        .slot_assign  (slot_assign),
        .shared_level (shared_level),
        .pair_low     (pair_low),
        .pair_high    (pair_high),
        .triple_low   (triple_low),
        .triple_mid   (triple_mid),
        .triple_high  (triple_high),
        .last_level4  (last_level4),
        .last_level5  (last_level5),
        .above        (above)
    );

    for (genvar i = 0; i < 24; i++) begin : g_input
        // Disabled inputs ignore samples and keep their last state
        assign hit[i] = sample_valid & run & in_en[i] & (sample_input == 5'(i));
        assign next_comp_state[i] = (hit[i] & ~mode[i])
                                  ? (sample_code > comp_code(comp_level[(i / 4) * 2 +: 2]))
                                  : comp_state[i];
        assign comp_evt[i] = next_comp_state[i] ^ comp_state[i];
    end

    for (genvar b = 0; b < 56; b++) begin : g_level
        localparam int IDX = input_of(b);
        localparam int LVL = level_of(b);
        assign next_adc_state[b] = (hit[IDX] & mode[IDX]) ? above[LVL] : adc_state[b];
        assign adc_evt[b] = next_adc_state[b] ^ adc_state[b];
    end

    always_comb begin
        logic clr_comp, clr_lo, clr_hi;
        clr_comp = reg_read & (reg_addr == `REG_IRQ_COMP);
        clr_lo   = reg_read & (reg_addr == `REG_IRQ_ADC_LO);
        clr_hi   = reg_read & (reg_addr == `REG_IRQ_ADC_HI);
        // New events win over a read clear in the same cycle
        next_irq_comp         = (clr_comp ? 24'h000000 : irq_comp) | comp_evt;
        next_irq_adc[31:0]    = (clr_lo ? 32'h00000000 : irq_adc[31:0]) | adc_evt[31:0];
        next_irq_adc[55:32]   = (clr_hi ? 24'h000000 : irq_adc[55:32]) | adc_evt[55:32];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            comp_state <= 24'h000000;
            adc_state  <= 56'h00000000000000;
            irq_comp   <= 24'h000000;
            irq_adc    <= 56'h00000000000000;
        end else begin
            comp_state <= next_comp_state;
            adc_state  <= next_adc_state;
            irq_comp   <= next_irq_comp;
            irq_adc    <= next_irq_adc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Contact cleaning pulse, timed in microsecond ticks

    ccp_state_t  ccp_state, next_ccp_state;
    logic [4:0]  tick_div, next_tick_div;
    logic [4:0]  clean_left, next_clean_left;
    logic        tick;

    assign tick = (tick_div == 5'(`TICK_CYCLES - 1));

    always_comb begin
        next_tick_div   = tick ? 5'h00 : tick_div + 5'h01;
        next_ccp_state  = ccp_state;
        next_clean_left = clean_left;
        case (ccp_state)
            ccp_idle: begin
                if (poll_cycle_end & ccp_en & run) begin
                    next_ccp_state  = ccp_clean;
                    next_clean_left = 5'(`CLEAN_PULSE_US);
                    next_tick_div   = 5'h00;
                end
            end
            ccp_clean: begin
                if (!run) begin
                    next_ccp_state = ccp_idle;
                end else if (tick) begin
                    next_clean_left = clean_left - 5'h01;
                    if (clean_left == 5'h01) begin
                        next_ccp_state = ccp_idle;
                    end
                end
            end
            default: next_ccp_state = ccp_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ccp_state  <= ccp_idle;
            tick_div   <= 5'h00;
            clean_left <= 5'h00;
        end else begin
            ccp_state  <= next_ccp_state;
            tick_div   <= next_tick_div;
            clean_left <= next_clean_left;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog controls, read port and interrupt

    logic [23:0] next_source;
    logic [9:0]  next_sink;
    logic [71:0] next_wet;
    logic [31:0] next_rdata;
    logic        cleaning;

    assign cleaning = (ccp_state == ccp_clean);

    for (genvar i = 0; i < 24; i++) begin : g_drive
        if (i < 10) begin : g_dual
            assign next_source[i] = run & in_en[i] & ~cs_select[i];
            assign next_sink[i]   = run & in_en[i] & cs_select[i];
        end else begin : g_source_only
            assign next_source[i] = run & in_en[i];
        end
        // Cleaning overrides the programmed current on every input
        assign next_wet[i * 3 +: 3] = cleaning ? `WET_CLEAN_CODE : wet_cfg[(i / 2) * 3 +: 3];
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_read) begin
            if (reg_addr[5:3] == `REG_SLOT_PAGE) begin
                next_rdata[9:0] = slots[int'(reg_addr[2:0]) * 10 +: 10];
            end
            case (reg_addr)
                `REG_RUN:          next_rdata[1:0]  = {ccp_en, run};
                `REG_CS_SELECT:    next_rdata[9:0]  = cs_select;
                `REG_MODE:         next_rdata[23:0] = mode;
                `REG_IN_EN:        next_rdata[23:0] = in_en;
                `REG_COMP_LEVEL:   next_rdata[11:0] = comp_level;
                `REG_WET_A:        next_rdata[17:0] = wet_cfg[17:0];
                `REG_WET_B:        next_rdata[17:0] = wet_cfg[35:18];
                `REG_SHARED:       next_rdata[9:0]  = shared_level;
                `REG_ASSIGN_A:     next_rdata[29:0] = slot_assign[29:0];
                `REG_ASSIGN_B:     next_rdata[5:0]  = slot_assign[35:30];
                `REG_PAIR_LOW:     next_rdata[9:0]  = pair_low;
                `REG_PAIR_HIGH:    next_rdata[9:0]  = pair_high;
                `REG_TRIPLE_LOW:   next_rdata[9:0]  = triple_low;
                `REG_TRIPLE_MID:   next_rdata[9:0]  = triple_mid;
                `REG_TRIPLE_HIGH:  next_rdata[9:0]  = triple_high;
                `REG_LAST_LEVEL4:  next_rdata[9:0]  = last_level4;
                `REG_LAST_LEVEL5:  next_rdata[9:0]  = last_level5;
                `REG_COMP_STATE:   next_rdata[23:0] = comp_state;
                `REG_ADC_STATE_LO: next_rdata       = adc_state[31:0];
                `REG_ADC_STATE_HI: next_rdata[23:0] = adc_state[55:32];
                `REG_IRQ_COMP:     next_rdata[23:0] = irq_comp;
                `REG_IRQ_ADC_LO:   next_rdata       = irq_adc[31:0];
                `REG_IRQ_ADC_HI:   next_rdata[23:0] = irq_adc[55:32];
                `REG_MASK_COMP:    next_rdata[23:0] = mask_comp;
                `REG_ADC_MASK_1:   next_rdata       = mask_adc[31:0];
                `REG_ADC_MASK_2:   next_rdata[23:0] = mask_adc[55:32];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata       <= 32'h00000000;
            source_enable   <= 24'h000000;
            sink_enable     <= 10'h000;
            wetting_code    <= 72'h000000000000000000;
            adc_path_select <= 24'h000000;
            running         <= 1'b0;
            cleaning_active <= 1'b0;
            irq             <= 1'b0;
        end else begin
            reg_rdata       <= next_rdata;
            source_enable   <= next_source;
            sink_enable     <= next_sink;
            wetting_code    <= next_wet;
            adc_path_select <= mode & in_en;
            running         <= run;
            cleaning_active <= cleaning;
            irq             <= |{next_irq_comp & mask_comp, next_irq_adc & mask_adc};
        end
    end
endmodule : switch_input_config

//--- src/switch_input_types.sv
// Types shared by the switch input configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package switch_input_types;
    typedef logic [2:0] wet_code_t;
    typedef logic [9:0] level_t;
    typedef enum logic [0:0] {
        ccp_idle,
        ccp_clean
    } ccp_state_t;
endpackage : switch_input_types
